// ===== rtl/icsq_pkg.sv
package icsq_pkg;

    // ************************************************************
    // Register offsets on the plain register port
    // ************************************************************
    localparam logic [3:0] ICSQ_OFF_CTRL = 4'h0; // Sequence enables, ack data
    localparam logic [3:0] ICSQ_OFF_STAT = 4'h1; // Status flags
    localparam logic [3:0] ICSQ_OFF_BAUD = 4'h2; // Baud reload value
    localparam logic [3:0] ICSQ_OFF_DATA = 4'h3; // Serial data buffer
    localparam logic [3:0] ICSQ_OFF_MODE = 4'h4; // Module enable

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int ICSQ_CTL_START = 0; // Start sequence enable
    localparam int ICSQ_CTL_RESTART = 1; // Repeated start enable
    localparam int ICSQ_CTL_STOP = 2; // Stop sequence enable
    localparam int ICSQ_CTL_ACK = 3; // Ack sequence enable
    localparam int ICSQ_CTL_ACK_DATA_VALUE = 4; // Ack data value

    // ************************************************************
    // Status register fields, written ones clear the sticky flags
    // ************************************************************
    localparam int ICSQ_ST_WRITE_COLLISION_FLAG = 0; // Write collision
    localparam int ICSQ_ST_BCOL = 1; // Bus collision
    localparam int ICSQ_ST_IRQ = 2; // Port interrupt flag
    localparam int ICSQ_ST_STOPD = 3; // Stop detected
    localparam int ICSQ_ST_STARTD = 4; // Start detected
    localparam int ICSQ_ST_BFULL = 5; // Buffer full

    // ************************************************************
    // Reset values and clock divider
    // ************************************************************
    localparam logic [7:0] ICSQ_BAUD_RST = 8'h27; // Default reload
    localparam logic [7:0] ICSQ_ZERO8 = 8'h00;
    localparam int ICSQ_BAUD_MULT = 2; // Clocks per reload count
    localparam int ICSQ_MIN_BAUD = 3; // Smallest legal reload

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ICSQ_IDLE = 4'b0000,
        ICSQ_ST_CHK = 4'b0001, // Start: wait first count, SDA high
        ICSQ_ST_HOLD = 4'b0010, // Start: SDA low, second count
        ICSQ_RS_SDA = 4'b0011, // Restart: release SDA, count
        ICSQ_RS_SCL = 4'b0100, // Restart: release SCL, wait high
        ICSQ_RS_CHK = 4'b0101, // Restart: both high, count
        ICSQ_RS_HOLD = 4'b0110, // Restart: SDA low, count
        ICSQ_AK_LOW = 4'b0111, // Ack: SCL low one period
        ICSQ_AK_WAIT = 4'b1000, // Ack: wait SCL high
        ICSQ_AK_HIGH = 4'b1001, // Ack: SCL high one period
        ICSQ_SP_SDA = 4'b1010, // Stop: wait SDA sampled low
        ICSQ_SP_LOW = 4'b1011, // Stop: count with SCL low
        ICSQ_SP_SCL = 4'b1100, // Stop: SCL high one period
        ICSQ_SP_DET = 4'b1101, // Stop: wait stop detected
        ICSQ_SP_END = 4'b1110 // Stop: final period
    } icsq_state_e;

    // Line levels travelling together
    typedef struct packed {
        logic scl;
        logic sda;
    } icsq_lines_s;

endpackage

// ===== rtl/icsq_sequencer.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module icsq_sequencer
    import icsq_pkg::*;
#(
    parameter int BAUD_W = 8 // Width of the reload value
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [3:0] ADDR_IN, // Register index
    input wire logic [7:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write strobe
    input wire logic RD_IN, // Read strobe
    output logic [7:0] RDATA_OUT, // Read data, cycle after strobe
    input wire logic SDA_IN, // Pin level
    output logic SDA_OUT, // Always low; enable decides
    output logic SDA_OE_N_OUT, // Low while pulling SDA low
    input wire logic SCL_IN, // Pin level
    output logic SCL_OUT, // Always low; enable decides
    output logic SCL_OE_N_OUT, // Low while pulling SCL low
    input wire logic TX_BUSY_IN, // Byte shifter is transmitting
    input wire logic TX_ONE_IN, // Shifter releases SDA for a one
    input wire logic TX_DONE_IN, // Shifter finished a byte
    output logic TX_ABORT_OUT, // Pulse: halt the shifter
    output logic TX_LOAD_OUT, // Pulse: start byte, first bit
    output logic [7:0] TX_DATA_OUT // Byte for the shifter
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    icsq_lines_s meta; // First stage, read only by second
    icsq_lines_s line; // Synchronised levels
    icsq_lines_s line_d; // Previous level for edges

    // Two flops on each pin before anything looks at it
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            meta <= '1;
            line <= '1;
            line_d <= '1;
        end else begin
            meta <= '{scl: SCL_IN, sda: SDA_IN};
            line <= meta;
            line_d <= line;
        end
    end

    // ************************************************************
    // Register file state
    // ************************************************************
    logic enable; // Module enable
    logic [4:0] ctrl; // Sequence enables and ack data
    logic [BAUD_W-1:0] baud; // Reload value
    logic [7:0] data_buf; // Serial data buffer
    logic write_collision_flag, bcol, irq, stopd, startd, bfull; // Flags
    icsq_state_e state;
    icsq_state_e next_state;
    logic [BAUD_W:0] cnt; // Baud down counter, doubled
    logic [BAUD_W:0] next_cnt;
    logic sda_low, scl_low; // Drive-low requests
    logic next_sda_low, next_scl_low;
    logic seq_done, seq_bcol; // Sequencer events this cycle

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr_ctrl = WR_IN && (ADDR_IN == ICSQ_OFF_CTRL);
    wire wr_stat = WR_IN && (ADDR_IN == ICSQ_OFF_STAT);
    wire wr_baud = WR_IN && (ADDR_IN == ICSQ_OFF_BAUD);
    wire wr_data = WR_IN && (ADDR_IN == ICSQ_OFF_DATA);
    wire wr_mode = WR_IN && (ADDR_IN == ICSQ_OFF_MODE);
    wire rd_data = RD_IN && (ADDR_IN == ICSQ_OFF_DATA);
    // Ack and stop sequences block the buffer, so do transfers
    wire seq_busy = (state >= ICSQ_AK_LOW) && (state <= ICSQ_SP_END);
    wire wr_refused = wr_data && (seq_busy || TX_BUSY_IN);
    wire wr_take = wr_data && !wr_refused && enable;
    wire disable_now = wr_mode && !WDATA_IN[0];
    // Bus conditions seen from the lines
    wire sda_rise = line.sda && !line_d.sda;
    wire sda_fall = !line.sda && line_d.sda;
    wire bus_stop = sda_rise && line.scl;
    wire bus_start = sda_fall && line.scl;
    // Released one read as zero while transmitting
    // Abort already raised: the shifter halts before it is re-flagged
    wire tx_coll = TX_BUSY_IN && TX_ONE_IN && line.scl &&
        !line.sda && line_d.scl && !TX_ABORT_OUT;
    wire bcol_any = seq_bcol || tx_coll;
    // Counter reload: two system clocks per reload count
    wire [BAUD_W:0] reload = {baud, 1'b0} + (BAUD_W+1)'(1);
    wire cnt_zero = (cnt == '0);

    // ************************************************************
    // Sequencer next state
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt_zero ? cnt : cnt - (BAUD_W+1)'(1);
        next_sda_low = sda_low;
        next_scl_low = scl_low;
        seq_done = 1'b0;
        seq_bcol = 1'b0;
        case (state)
            ICSQ_IDLE: begin
                // Idle: the start flag wins over others if several set
                if (ctrl[ICSQ_CTL_START]) begin
                    if (!line.sda || !line.scl) begin
                        seq_bcol = 1'b1;
                    end else begin
                        next_cnt = reload;
                        next_state = ICSQ_ST_CHK;
                    end
                end else if (ctrl[ICSQ_CTL_RESTART]) begin
                    next_sda_low = 1'b0;
                    next_cnt = reload;
                    next_state = ICSQ_RS_SDA;
                end else if (ctrl[ICSQ_CTL_ACK]) begin
                    next_scl_low = 1'b1;
                    next_sda_low = !ctrl[ICSQ_CTL_ACK_DATA_VALUE];
                    next_cnt = reload;
                    next_state = ICSQ_AK_LOW;
                end else if (ctrl[ICSQ_CTL_STOP]) begin
                    next_sda_low = 1'b1;
                    next_state = ICSQ_SP_SDA;
                end
            end
            ICSQ_ST_CHK: begin
                if (!line.sda) begin
                    next_sda_low = 1'b1;
                    next_cnt = reload;
                    next_state = ICSQ_ST_HOLD;
                end else if (!line.scl) begin
                    seq_bcol = 1'b1;
                end else if (cnt_zero) begin
                    next_sda_low = 1'b1;
                    next_cnt = reload;
                    next_state = ICSQ_ST_HOLD;
                end
            end
            ICSQ_ST_HOLD: begin
                // SCL low here is ignored
                if (cnt_zero) begin
                    next_scl_low = 1'b1;
                    seq_done = 1'b1;
                end
            end
            ICSQ_RS_SDA: begin
                if (cnt_zero) begin
                    next_scl_low = 1'b0;
                    next_state = ICSQ_RS_SCL;
                end
            end
            ICSQ_RS_SCL: begin
                if (line.scl) begin
                    if (!line.sda) begin
                        seq_bcol = 1'b1;
                    end else begin
                        next_cnt = reload;
                        next_state = ICSQ_RS_CHK;
                    end
                end
            end
            ICSQ_RS_CHK: begin
                if (!line.scl && line.sda) begin
                    seq_bcol = 1'b1;
                end else if (cnt_zero) begin
                    // SDA pulled early by another master is no collision
                    next_sda_low = 1'b1;
                    next_cnt = reload;
                    next_state = ICSQ_RS_HOLD;
                end
            end
            ICSQ_RS_HOLD: begin
                if (cnt_zero) begin
                    next_scl_low = 1'b1;
                    seq_done = 1'b1;
                end
            end
            ICSQ_AK_LOW: begin
                if (cnt_zero) begin
                    next_scl_low = 1'b0;
                    next_state = ICSQ_AK_WAIT;
                end
            end
            ICSQ_AK_WAIT: begin
                if (line.scl) begin
                    next_cnt = reload;
                    next_state = ICSQ_AK_HIGH;
                end
            end
            ICSQ_AK_HIGH: begin
                if (!next_sda_low && !line.sda && line.scl) begin
                    seq_bcol = 1'b1;
                end else if (cnt_zero) begin
                    next_scl_low = 1'b1;
                    seq_done = 1'b1;
                end
            end
            ICSQ_SP_SDA: begin
                if (!line.sda) begin
                    next_cnt = reload;
                    next_state = ICSQ_SP_LOW;
                end
            end
            ICSQ_SP_LOW: begin
                if (cnt_zero) begin
                    next_scl_low = 1'b0;
                    next_cnt = reload;
                    next_state = ICSQ_SP_SCL;
                end
            end
            ICSQ_SP_SCL: begin
                if (cnt_zero) begin
                    next_sda_low = 1'b0;
                    next_state = ICSQ_SP_DET;
                end
            end
            ICSQ_SP_DET: begin
                if (line.sda && line.scl) begin
                    next_cnt = reload;
                    next_state = ICSQ_SP_END;
                end
            end
            ICSQ_SP_END: begin
                if (cnt_zero) begin
                    seq_done = 1'b1;
                end
            end
            default: begin
                next_state = ICSQ_IDLE;
            end
        endcase
        // Completion or collision stops the counter and idles
        if (seq_done || seq_bcol) begin
            next_state = ICSQ_IDLE;
            next_cnt = '0;
        end
        // Collision lets both lines go
        if (bcol_any) begin
            next_sda_low = 1'b0;
            next_scl_low = 1'b0;
            next_state = ICSQ_IDLE;
            next_cnt = '0;
        end
    end

    // ************************************************************
    // Sequencer registers
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= ICSQ_IDLE;
            cnt <= '0;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
        end else if (!enable) begin
            state <= ICSQ_IDLE;
            cnt <= '0;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sda_low <= next_sda_low;
            scl_low <= next_scl_low;
        end
    end

    // ************************************************************
    // Control bits: hardware clears all four enables when a sequence finishes or a collision aborts
    // ************************************************************
    wire seq_end = seq_done || bcol_any;
    wire [4:0] next_ctrl = !enable ? 5'h00 :
        (wr_ctrl ? WDATA_IN[4:0] : ctrl) &
        (seq_end ? 5'h10 : 5'h1F);

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl <= 5'h00;
            enable <= 1'b0;
            baud <= ICSQ_BAUD_RST;
            data_buf <= ICSQ_ZERO8;
        end else begin
            ctrl <= next_ctrl;
            enable <= wr_mode ? WDATA_IN[0] : enable;
            baud <= wr_baud ? WDATA_IN[BAUD_W-1:0] : baud;
            data_buf <= wr_take ? WDATA_IN : data_buf;
        end
    end

    // ************************************************************
    // Sticky flags: a set in the clear cycle wins
    // ************************************************************
    wire [5:0] clr = wr_stat ? WDATA_IN[5:0] : 6'h00;
    wire irq_set = seq_done || (bus_stop && (bcol || bcol_any)) ||
        TX_DONE_IN;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            write_collision_flag <= 1'b0;
            bcol <= 1'b0;
            irq <= 1'b0;
            stopd <= 1'b0;
            startd <= 1'b0;
            bfull <= 1'b0;
        end else begin
            write_collision_flag <= wr_refused || (write_collision_flag && !clr[ICSQ_ST_WRITE_COLLISION_FLAG]);
            bcol <= bcol_any || (bcol && !clr[ICSQ_ST_BCOL]);
            irq <= irq_set || (irq && !clr[ICSQ_ST_IRQ]);
            // Bus-state flags follow the last condition seen
            stopd <= enable && !disable_now &&
                (bus_stop || (stopd && !bus_start));
            startd <= enable && !disable_now &&
                (bus_start || (startd && !bus_stop));
            // Transmit collision, finished byte or data read empties the buffer
            bfull <= wr_take || (bfull && !tx_coll && !TX_DONE_IN &&
                !rd_data);
        end
    end

    // ************************************************************
    // Outputs, all from flops
    // ************************************************************
    wire [7:0] stat_word = {2'b00, bfull, startd, stopd, irq, bcol, write_collision_flag};
    wire [7:0] rd_mux =
        (ADDR_IN == ICSQ_OFF_CTRL) ? {3'b000, ctrl} :
        (ADDR_IN == ICSQ_OFF_STAT) ? stat_word :
        (ADDR_IN == ICSQ_OFF_BAUD) ? 8'(baud) :
        (ADDR_IN == ICSQ_OFF_DATA) ? data_buf :
        (ADDR_IN == ICSQ_OFF_MODE) ? {7'h00, enable} : 8'h00;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 8'h00;
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
            SDA_OE_N_OUT <= 1'b1;
            SCL_OE_N_OUT <= 1'b1;
            TX_ABORT_OUT <= 1'b0;
            TX_LOAD_OUT <= 1'b0;
            TX_DATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
            // Open drain: only ever pull low, else release
            SDA_OE_N_OUT <= !(enable && next_sda_low && !bcol_any);
            SCL_OE_N_OUT <= !(enable && next_scl_low && !bcol_any);
            TX_ABORT_OUT <= tx_coll;
            TX_LOAD_OUT <= wr_take;
            TX_DATA_OUT <= wr_take ? WDATA_IN : TX_DATA_OUT;
        end
    end

endmodule // icsq_sequencer

// ===== bench/icsq_checker.sv
`timescale 1ns/10ps
// ****************************************************************
// Port checker: watches only the sequencer's pins
// ****************************************************************
module icsq_checker
    import icsq_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N_OUT,
    input wire logic SCL_IN,
    input wire logic SCL_OUT,
    input wire logic SCL_OE_N_OUT,
    input wire logic TX_BUSY_IN,
    input wire logic TX_ONE_IN,
    input wire logic TX_DONE_IN,
    input wire logic TX_ABORT_OUT,
    input wire logic TX_LOAD_OUT,
    input wire logic [7:0] TX_DATA_OUT
);
    // One domain, so clock and reset are declared once
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    chk_reset_idle: assert property (
        $fell(RST_IN) |-> SDA_OE_N_OUT && SCL_OE_N_OUT)
        else $error("lines not released after reset");
    chk_pins_low: assert property (
        SDA_OUT == 1'b0 && SCL_OUT == 1'b0)
        else $error("pin driven high");
    chk_rdata_quiet: assert property (
        !$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data without read");
    chk_load_cause: assert property (
        TX_LOAD_OUT |-> $past(WR_IN) && !$past(TX_BUSY_IN)
            && $past(ADDR_IN) == ICSQ_OFF_DATA)
        else $error("load without accepted write");
    chk_busy_refuse: assert property (
        WR_IN && ADDR_IN == ICSQ_OFF_DATA && TX_BUSY_IN |=> !TX_LOAD_OUT)
        else $error("write accepted while busy");
    chk_load_data: assert property (
        TX_LOAD_OUT |-> TX_DATA_OUT == $past(WDATA_IN))
        else $error("wrong byte to shifter");
    chk_abort_pulse: assert property (
        TX_ABORT_OUT |=> !TX_ABORT_OUT)
        else $error("abort longer than one cycle");
    chk_abort_free: assert property (
        TX_ABORT_OUT |-> ##[0:2] (SDA_OE_N_OUT && SCL_OE_N_OUT))
        else $error("lines held after abort");
    // A clock low phase never shorter than four clocks, half the smallest baud period
    chk_scl_hold: assert property (
        $fell(SCL_OE_N_OUT) |=> !SCL_OE_N_OUT [*3])
        else $error("clock low phase too short");
endmodule // icsq_checker

// ===== bench/icsq_bus_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Far side: other masters and slaves on a wired-AND bus
// ****************************************************************
module icsq_bus_model
    import icsq_pkg::*;
(
    input wire logic sda_oe_n_in, // Sequencer pulls SDA when low
    input wire logic scl_oe_n_in, // Sequencer pulls SCL when low
    input wire logic pull_sda_in, // Another party pulls SDA
    input wire logic pull_scl_in, // Another party stretches SCL
    output icsq_lines_s lines_out // Resolved levels with pull-ups
);
    // Released lines float high through the pull-ups
    assign lines_out = '{scl: scl_oe_n_in & ~pull_scl_in,
        sda: sda_oe_n_in & ~pull_sda_in};
endmodule // icsq_bus_model

// ===== bench/icsq_sequencer_test.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the condition sequencer
// ****************************************************************
module icsq_sequencer_test
    import icsq_pkg::*;
;
    localparam logic [7:0] BAUD = 8'h03; // Smallest legal reload
    localparam int PER = 2 * BAUD + 2; // Clocks per baud period
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, tx_data, last_load;
    logic tx_busy = 1'b0, tx_one = 1'b0, tx_done = 1'b0;
    logic pull_sda = 1'b0, pull_scl = 1'b0; // Far side commands
    logic sda_o, scl_o, sda_oe_n, scl_oe_n, tx_abort, tx_load;
    logic [15:0] rnd = 16'hAF8E; // Fixed seed
    icsq_lines_s lines;
    int n_errors = 0, checks = 0, cyc = 0, loads = 0, n, k;

    initial forever #5 clk = ~clk;

    icsq_sequencer i_icsq_sequencer (.CLK_IN(clk), .RST_IN(rst),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
        .RDATA_OUT(rdata), .SDA_IN(lines.sda), .SDA_OUT(sda_o),
        .SDA_OE_N_OUT(sda_oe_n), .SCL_IN(lines.scl), .SCL_OUT(scl_o),
        .SCL_OE_N_OUT(scl_oe_n), .TX_BUSY_IN(tx_busy), .TX_ONE_IN(tx_one),
        .TX_DONE_IN(tx_done), .TX_ABORT_OUT(tx_abort),
        .TX_LOAD_OUT(tx_load), .TX_DATA_OUT(tx_data));
    icsq_bus_model i_icsq_bus_model (.sda_oe_n_in(sda_oe_n),
        .scl_oe_n_in(scl_oe_n), .pull_sda_in(pull_sda),
        .pull_scl_in(pull_scl), .lines_out(lines));

    // Count loads to the shifter; a hung run ends as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_load === 1'b1) begin
            loads <= loads + 1;
            last_load <= tx_data;
        end
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_sim();
        $display("checks %0d, n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic rdm(input logic [3:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d & m, e);
    endtask
    // Poll control bits with a bounded count
    task automatic idle(input logic [7:0] m);
        logic [7:0] d;
        for (int i = 0; i < 200; i++) begin
            rd(ICSQ_OFF_CTRL, d);
            if ((d & m) == 8'h00) break;
        end
    endtask
    // Cycles for which an enable keeps the given level
    task automatic span(input logic sel, input logic lvl, output int c);
        c = 0;
        while (((sel ? scl_oe_n : sda_oe_n) === lvl) && c < 400) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdm(ICSQ_OFF_CTRL, 8'hFF, 8'h00);
        rdm(ICSQ_OFF_STAT, 8'hFF, 8'h00);
        rdm(ICSQ_OFF_BAUD, 8'hFF, ICSQ_BAUD_RST);
        rdm(4'hF, 8'hFF, 8'h00);
        wr(ICSQ_OFF_BAUD, BAUD);
        wr(ICSQ_OFF_MODE, 8'h01);
        // Ack then nack, buffer write refused meanwhile
        for (int a = 0; a < 2; a++) begin
            wr(ICSQ_OFF_CTRL, {3'h0, a[0], 4'h8});
            @(negedge clk);
            chk({scl_oe_n, sda_oe_n}, {1'b0, a[0]});
            @(posedge clk);
            // Far side stretches SCL before the release
            pull_scl <= 1'b1;
            n = loads;
            wr(ICSQ_OFF_DATA, 8'h5A);
            rdm(ICSQ_OFF_STAT, 8'h01, 8'h01);
            chk(8'(loads - n), 8'h00);
            span(1'b1, 1'b0, k);
            repeat (20) @(posedge clk);
            pull_scl <= 1'b0;
            span(1'b1, 1'b1, k);
            chk(8'(k >= PER && k <= PER + 4), 8'h01);
            idle(8'h08);
            rdm(ICSQ_OFF_CTRL, 8'h08, 8'h00);
            chk(scl_oe_n, 1'b0);
            wr(ICSQ_OFF_STAT, 8'h07);
        end
        // Stop: SDA low, a period, SCL up, a period, SDA up
        wr(ICSQ_OFF_CTRL, 8'h04);
        @(negedge clk);
        chk(sda_oe_n, 1'b0);
        span(1'b1, 1'b0, k);
        chk(8'(k >= PER && k <= PER + 4), 8'h01);
        span(1'b0, 1'b0, k);
        chk(8'(k >= PER - 1 && k <= PER + 4), 8'h01);
        idle(8'h04);
        rdm(ICSQ_OFF_CTRL, 8'h04, 8'h00);
        rdm(ICSQ_OFF_STAT, 8'h0C, 8'h0C);
        wr(ICSQ_OFF_STAT, 8'h07);
        // A one read as zero while transmitting, buffer full
        wr(ICSQ_OFF_DATA, 8'hC3);
        tx_busy <= 1'b1;
        tx_one <= 1'b1;
        pull_sda <= 1'b1;
        k = 0;
        while (tx_abort !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk(8'(k < 40), 8'h01);
        @(posedge clk);
        // Shifter halts on the abort
        tx_busy <= 1'b0;
        tx_one <= 1'b0;
        rdm(ICSQ_OFF_STAT, 8'h22, 8'h02);
        wr(ICSQ_OFF_STAT, 8'h04);
        pull_sda <= 1'b0;
        repeat (10) @(posedge clk);
        rdm(ICSQ_OFF_STAT, 8'h04, 8'h04);
        wr(ICSQ_OFF_STAT, 8'h07);
        // Start while another party holds SCL low
        pull_scl <= 1'b1;
        repeat (2) @(posedge clk);
        wr(ICSQ_OFF_CTRL, 8'h01);
        idle(8'h01);
        rdm(ICSQ_OFF_CTRL, 8'h01, 8'h00);
        rdm(ICSQ_OFF_STAT, 8'h02, 8'h02);
        chk({scl_oe_n, sda_oe_n}, 2'b11);
        pull_scl <= 1'b0;
        wr(ICSQ_OFF_STAT, 8'h07);
        // Bus free: stop seen last
        rdm(ICSQ_OFF_STAT, 8'h18, 8'h08);
        // Clean start, then repeated start
        wr(ICSQ_OFF_CTRL, 8'h01);
        idle(8'h01);
        chk({scl_oe_n, sda_oe_n}, 2'b00);
        rdm(ICSQ_OFF_STAT, 8'h12, 8'h10);
        wr(ICSQ_OFF_CTRL, 8'h02);
        @(negedge clk);
        chk(sda_oe_n, 1'b1);
        @(posedge clk);
        idle(8'h02);
        chk({scl_oe_n, sda_oe_n}, 2'b00);
        // Random buffer writes, busy or not
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            tx_busy <= rnd[0];
            n = loads;
            @(posedge clk);
            wr(ICSQ_OFF_DATA, rnd[15:8]);
            @(posedge clk);
            chk(8'(loads - n), {7'h0, ~rnd[0]});
            if (!rnd[0]) chk(last_load, rnd[15:8]);
            else rdm(ICSQ_OFF_STAT, 8'h01, 8'h01);
            wr(ICSQ_OFF_STAT, 8'h07);
        end
        tx_busy <= 1'b0;
        tx_done <= 1'b1;
        @(posedge clk);
        tx_done <= 1'b0;
        @(posedge clk);
        rdm(ICSQ_OFF_STAT, 8'h24, 8'h04);
        // Reset in mid-stop, then the disabled module stays quiet
        wr(ICSQ_OFF_CTRL, 8'h04);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({scl_oe_n, sda_oe_n}, 2'b11);
        @(posedge clk);
        rdm(ICSQ_OFF_STAT, 8'h18, 8'h00);
        wr(ICSQ_OFF_CTRL, 8'h08);
        @(negedge clk);
        chk(scl_oe_n, 1'b1);
        end_sim();
    end
endmodule // icsq_sequencer_test

bind icsq_sequencer icsq_checker i_icsq_checker (.CLK_IN(CLK_IN),
    .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT), .SCL_IN(SCL_IN),
    .SCL_OUT(SCL_OUT), .SCL_OE_N_OUT(SCL_OE_N_OUT),
    .TX_BUSY_IN(TX_BUSY_IN), .TX_ONE_IN(TX_ONE_IN),
    .TX_DONE_IN(TX_DONE_IN), .TX_ABORT_OUT(TX_ABORT_OUT),
    .TX_LOAD_OUT(TX_LOAD_OUT), .TX_DATA_OUT(TX_DATA_OUT));
